// file: rtl/gpt_pkg.sv
/*
 constants for the 32-bit general-purpose timer: register map, control
 field layout, codes, count-format limits and reset values.
 assumes nothing of its surroundings.
*/
`default_nettype none
package gpt_pkg;
    // register byte addresses
    localparam logic [31:0] GPT_ADDR_RELOAD  = 32'hffff0320;
    localparam logic [31:0] GPT_ADDR_COUNT   = 32'hffff0324;
    localparam logic [31:0] GPT_ADDR_CONTROL = 32'hffff0328;
    localparam logic [31:0] GPT_ADDR_CLEAR   = 32'hffff032c;
    localparam logic [31:0] GPT_ADDR_CAPTURE = 32'hffff0330;
    localparam logic [31:0] GPT_ADDR_STATUS  = 32'hffff0334;
    localparam logic [31:0] GPT_ADDR_MASK    = 32'hffff0338;

    // control fields
    localparam int GPT_CTL_PRESC_LO  = 0;
    localparam int GPT_CTL_PRESC_HI  = 3;
    localparam int GPT_CTL_FMT_LO    = 4;
    localparam int GPT_CTL_FMT_HI    = 5;
    localparam int GPT_CTL_PERIODIC  = 6;
    localparam int GPT_CTL_ENABLE    = 7;
    localparam int GPT_CTL_UP        = 8;
    localparam int GPT_CTL_CLK_LO    = 9;
    localparam int GPT_CTL_CLK_HI    = 11;
    localparam int GPT_CTL_EVT_LO    = 12;
    localparam int GPT_CTL_EVT_HI    = 16;
    localparam int GPT_CTL_CAP_EN    = 17;
    localparam int GPT_CTL_IRQ_SEL   = 18;
    localparam int GPT_CTL_POST_FLAG = 19;
    localparam int GPT_CTL_POST_WE   = 23;
    localparam int GPT_CTL_POST_LO   = 24;
    localparam int GPT_CTL_POST_HI   = 31;

    // clock source codes
    localparam logic [2:0] GPT_CLK_OSC32K = 3'h0;
    localparam logic [2:0] GPT_CLK_CORE   = 3'h1;
    localparam logic [2:0] GPT_CLK_PLL    = 3'h2;
    localparam logic [2:0] GPT_CLK_PIN    = 3'h3;

    // prescaler codes and their terminal counts
    localparam logic [3:0]  GPT_PRESC_1      = 4'h0;
    localparam logic [3:0]  GPT_PRESC_16     = 4'h4;
    localparam logic [3:0]  GPT_PRESC_256    = 4'h8;
    localparam logic [3:0]  GPT_PRESC_32768  = 4'hf;
    localparam logic [14:0] GPT_PTOP_1       = 15'h0000;
    localparam logic [14:0] GPT_PTOP_16      = 15'h000f;
    localparam logic [14:0] GPT_PTOP_256     = 15'h00ff;
    localparam logic [14:0] GPT_PTOP_32768   = 15'h7fff;

    // count formats
    localparam logic [1:0] GPT_FMT_BINARY = 2'h0;
    localparam logic [1:0] GPT_FMT_HMS24  = 2'h2;
    localparam logic [1:0] GPT_FMT_HMS256 = 2'h3;

    // time-format field limits
    localparam logic [7:0] GPT_HUND_MAX   = 8'h63;
    localparam logic [7:0] GPT_SEXA_MAX   = 8'h3b;
    localparam logic [7:0] GPT_HOUR24_MAX = 8'h17;
    localparam logic [7:0] GPT_HOUR_FULL  = 8'hff;

    // interrupt status bits
    localparam int GPT_IRQ_W       = 2;
    localparam int GPT_IRQ_TIMEOUT = 0;
    localparam int GPT_IRQ_CAPTURE = 1;

    localparam int GPT_NUM_SRC = 17;

    // reset values
    localparam logic [31:0] GPT_RST_WORD = 32'h0000_0000;
    localparam logic [31:0] GPT_ALL_ONES = 32'hffff_ffff;
endpackage
`default_nettype wire

// file: rtl/gpt_timer.sv
/*
 32-bit general-purpose up/down timer with prescaler, time formats,
 reload, event capture, postscaler and masked level interrupt.
 assumes a single-cycle register port with read data one cycle after the
 read strobe, and clock-source inputs that are synchronous to ref_clk.
*/
//
// Behaviour
// - control bit 8 set counts up, clear counts down, down after reset.
// - control bits 11:9 pick the 32 kHz oscillator, core clock, pll clock or pin.
// - control bits 3:0 divide the chosen source by 1, 16, 256 or 32768.
// - control bits 5:4 choose binary, 24-hour time format or 256-hour time format.
// - the counter moves only while control bit 7 is set, clear after reset.
// - control bit 6 set gives periodic mode, clear gives free-running mode.
// - the counter reloads from the reload value on overflow in periodic mode and at once on a clear write.
// - a write to the clear register drops the pending timer interrupt, except when a timeout sets it in the same cycle.
// - with bit 17 set a rising selected event copies the count into capture.
// - control bits 16:12 pick which of event sources 0 to 16 triggers capture.
// - bits 31:24 hold the postscaler, written only when bit 23 of the write is set.
// - bit 19 flags a postscaler match and bit 18 makes the interrupt wait for it.
// - oscillator and pin sources keep counting during low-power mode.
// - count and capture registers are read-only, the count read is live.
`default_nettype none
module gpt_timer
    import gpt_pkg::*;
#(
    parameter int NUM_SRC = GPT_NUM_SRC
) (
    input  wire logic               ref_clk,
    input  wire logic               nrst,
    input  wire logic [31:0]        bus_addr,
    input  wire logic [31:0]        bus_wdata,
    input  wire logic               bus_wr,
    input  wire logic               bus_rd,
    output var  logic [31:0]        bus_rdata,
    input  wire logic               osc_32k_clk,
    input  wire logic               undivided_pll_clock,
    input  wire logic               external_clock_pin,
    input  wire logic               low_power,
    input  wire logic [NUM_SRC-1:0] irq_sources,
    output var  logic               irq
);

    logic [31:0]        reload_value;
    logic [31:0]        count_value;
    logic [31:0]        captured_value;
    logic [3:0]         presc_code;
    logic [1:0]         fmt_code;
    logic               periodic;
    logic               enable;
    logic               count_up;
    logic [2:0]         clk_sel;
    logic [4:0]         evt_sel;
    logic               cap_en;
    logic               irq_sel;
    logic               post_flag;
    logic [7:0]         postscale;
    logic [7:0]         post_cnt;
    logic [14:0]        presc_cnt;
    logic [GPT_IRQ_W-1:0] irq_status;
    logic [GPT_IRQ_W-1:0] irq_mask;
    logic               osc_prev;
    logic               pll_prev;
    logic               pin_prev;
    logic [NUM_SRC-1:0] src_prev;

    logic               wr_reload;
    logic               wr_control;
    logic               wr_clear;
    logic               wr_status;
    logic               wr_mask;
    logic               src_tick;
    logic               cnt_tick;
    logic [14:0]        presc_top;
    logic               terminal;
    logic [31:0]        next_count;
    logic [31:0]        wrap_value;
    logic               post_match;
    logic               timeout_evt;
    logic               capture_evt;
    logic [31:0]        next_rdata;
    logic [7:0]         hour_max;
    logic               hms_mode;

    // one step of the time format, carries and borrows between fields
    function automatic logic [31:0] hms_step(input logic [31:0] v,
                                             input logic        up,
                                             input logic [7:0]  hmax);
        logic [7:0] h;
        logic [7:0] m;
        logic [7:0] s;
        logic [7:0] c;
        h = v[31:24];
        m = v[23:16];
        s = v[15:8];
        c = v[7:0];
        if (up) begin
            if (c < GPT_HUND_MAX) begin
                c = c + 8'h01;
            end else begin
                c = 8'h00;
                if (s < GPT_SEXA_MAX) begin
                    s = s + 8'h01;
                end else begin
                    s = 8'h00;
                    if (m < GPT_SEXA_MAX) begin
                        m = m + 8'h01;
                    end else begin
                        m = 8'h00;
                        h = (h < hmax) ? h + 8'h01 : 8'h00;
                    end
                end
            end
        end else begin
            if (c != 8'h00) begin
                c = c - 8'h01;
            end else begin
                c = GPT_HUND_MAX;
                if (s != 8'h00) begin
                    s = s - 8'h01;
                end else begin
                    s = GPT_SEXA_MAX;
                    if (m != 8'h00) begin
                        m = m - 8'h01;
                    end else begin
                        m = GPT_SEXA_MAX;
                        h = (h != 8'h00) ? h - 8'h01 : hmax;
                    end
                end
            end
        end
        return {h, m, s, c};
    endfunction

    // register decode
    always_comb begin
        wr_reload  = 1'b0;
        wr_control = 1'b0;
        wr_clear   = 1'b0;
        wr_status  = 1'b0;
        wr_mask    = 1'b0;
        if (bus_wr) begin
            if (bus_addr == GPT_ADDR_RELOAD) begin
                wr_reload = 1'b1;
            end else if (bus_addr == GPT_ADDR_CONTROL) begin
                wr_control = 1'b1;
            end else if (bus_addr == GPT_ADDR_CLEAR) begin
                wr_clear = 1'b1;
            end else if (bus_addr == GPT_ADDR_STATUS) begin
                wr_status = 1'b1;
            end else if (bus_addr == GPT_ADDR_MASK) begin
                wr_mask = 1'b1;
            end
        end
    end

    // source edge detection, core and pll stop in low power
    always_comb begin
        case (clk_sel)
            GPT_CLK_OSC32K: src_tick = osc_32k_clk & ~osc_prev;
            GPT_CLK_CORE:   src_tick = ~low_power;
            GPT_CLK_PLL:    src_tick = undivided_pll_clock & ~pll_prev & ~low_power;
            GPT_CLK_PIN:    src_tick = external_clock_pin & ~pin_prev;
            default:        src_tick = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            osc_prev <= 1'b0;
            pll_prev <= 1'b0;
            pin_prev <= 1'b0;
            src_prev <= '0;
        end else begin
            osc_prev <= osc_32k_clk;
            pll_prev <= undivided_pll_clock;
            pin_prev <= external_clock_pin;
            src_prev <= irq_sources;
        end
    end

    // prescaler; undefined codes divide by one
    always_comb begin
        case (presc_code)
            GPT_PRESC_16:    presc_top = GPT_PTOP_16;
            GPT_PRESC_256:   presc_top = GPT_PTOP_256;
            GPT_PRESC_32768: presc_top = GPT_PTOP_32768;
            default:         presc_top = GPT_PTOP_1;
        endcase
    end

    assign cnt_tick = enable & src_tick & (presc_cnt >= presc_top);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            presc_cnt <= 15'h0000;
        end else if (!enable || wr_clear) begin
            presc_cnt <= 15'h0000;
        end else if (src_tick) begin
            presc_cnt <= (presc_cnt >= presc_top) ? 15'h0000 : presc_cnt + 15'h0001;
        end
    end

    // count step, terminal detection and wrap value
    assign hms_mode = (fmt_code == GPT_FMT_HMS24) || (fmt_code == GPT_FMT_HMS256);
    assign hour_max = (fmt_code == GPT_FMT_HMS24) ? GPT_HOUR24_MAX : GPT_HOUR_FULL;

    always_comb begin
        if (hms_mode) begin
            if (count_up) begin
                terminal   = (count_value[31:24] >= hour_max) &&
                             (count_value[23:16] >= GPT_SEXA_MAX) &&
                             (count_value[15:8] >= GPT_SEXA_MAX) &&
                             (count_value[7:0] >= GPT_HUND_MAX);
                wrap_value = GPT_RST_WORD;
            end else begin
                terminal   = (count_value == GPT_RST_WORD);
                wrap_value = {hour_max, GPT_SEXA_MAX, GPT_SEXA_MAX, GPT_HUND_MAX};
            end
            next_count = hms_step(count_value, count_up, hour_max);
        end else begin
            if (count_up) begin
                terminal   = (count_value == GPT_ALL_ONES);
                wrap_value = GPT_RST_WORD;
                next_count = count_value + 32'h0000_0001;
            end else begin
                terminal   = (count_value == GPT_RST_WORD);
                wrap_value = GPT_ALL_ONES;
                next_count = count_value - 32'h0000_0001;
            end
        end
    end

    // clear write reloads at once; free-running wraps instead of reloading
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count_value <= GPT_RST_WORD;
        end else if (wr_clear) begin
            count_value <= reload_value;
        end else if (cnt_tick) begin
            if (terminal) begin
                count_value <= periodic ? reload_value : wrap_value;
            end else begin
                count_value <= next_count;
            end
        end
    end

    // postscaler counts terminal events
    assign post_match  = cnt_tick & terminal & (post_cnt == postscale);
    assign timeout_evt = cnt_tick & terminal & (~irq_sel | post_match);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            post_cnt <= 8'h00;
        end else if (wr_clear) begin
            post_cnt <= 8'h00;
        end else if (cnt_tick && terminal) begin
            post_cnt <= post_match ? 8'h00 : post_cnt + 8'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            post_flag <= 1'b0;
        end else if (post_match) begin
            post_flag <= 1'b1;
        end else if (wr_clear) begin
            post_flag <= 1'b0;
        end
    end

    // capture on rising edge of the selected event source
    assign capture_evt = cap_en && (evt_sel < NUM_SRC) &&
                         irq_sources[evt_sel] && !src_prev[evt_sel];

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            captured_value <= GPT_RST_WORD;
        end else if (capture_evt) begin
            captured_value <= count_value;
        end
    end

    // software registers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reload_value <= GPT_RST_WORD;
        end else if (wr_reload) begin
            reload_value <= bus_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            presc_code <= GPT_PRESC_1;
            fmt_code   <= GPT_FMT_BINARY;
            periodic   <= 1'b0;
            enable     <= 1'b0;
            count_up   <= 1'b0;
            clk_sel    <= GPT_CLK_OSC32K;
            evt_sel    <= 5'h00;
            cap_en     <= 1'b0;
            irq_sel    <= 1'b0;
        end else if (wr_control) begin
            presc_code <= bus_wdata[GPT_CTL_PRESC_HI:GPT_CTL_PRESC_LO];
            fmt_code   <= bus_wdata[GPT_CTL_FMT_HI:GPT_CTL_FMT_LO];
            periodic   <= bus_wdata[GPT_CTL_PERIODIC];
            enable     <= bus_wdata[GPT_CTL_ENABLE];
            count_up   <= bus_wdata[GPT_CTL_UP];
            clk_sel    <= bus_wdata[GPT_CTL_CLK_HI:GPT_CTL_CLK_LO];
            evt_sel    <= bus_wdata[GPT_CTL_EVT_HI:GPT_CTL_EVT_LO];
            cap_en     <= bus_wdata[GPT_CTL_CAP_EN];
            irq_sel    <= bus_wdata[GPT_CTL_IRQ_SEL];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            postscale <= 8'h00;
        end else if (wr_control && bus_wdata[GPT_CTL_POST_WE]) begin
            postscale <= bus_wdata[GPT_CTL_POST_HI:GPT_CTL_POST_LO];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_mask <= '0;
        end else if (wr_mask) begin
            irq_mask <= bus_wdata[GPT_IRQ_W-1:0];
        end
    end

    // sticky status: a set in the clearing cycle survives
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_status <= '0;
        end else begin
            irq_status[GPT_IRQ_TIMEOUT] <= timeout_evt |
                (irq_status[GPT_IRQ_TIMEOUT] & ~wr_clear &
                 ~(wr_status & bus_wdata[GPT_IRQ_TIMEOUT]));
            irq_status[GPT_IRQ_CAPTURE] <= capture_evt |
                (irq_status[GPT_IRQ_CAPTURE] &
                 ~(wr_status & bus_wdata[GPT_IRQ_CAPTURE]));
        end
    end

    // registered output, one cycle behind the status bits
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // read mux; write-only and unmapped addresses read zero
    always_comb begin
        next_rdata = GPT_RST_WORD;
        if (bus_addr == GPT_ADDR_RELOAD) begin
            next_rdata = reload_value;
        end else if (bus_addr == GPT_ADDR_COUNT) begin
            next_rdata = count_value;
        end else if (bus_addr == GPT_ADDR_CONTROL) begin
            next_rdata = {postscale, 4'h0, post_flag, irq_sel, cap_en, evt_sel,
                          clk_sel, count_up, enable, periodic, fmt_code, presc_code};
        end else if (bus_addr == GPT_ADDR_CAPTURE) begin
            next_rdata = captured_value;
        end else if (bus_addr == GPT_ADDR_STATUS) begin
            next_rdata[GPT_IRQ_W-1:0] = irq_status;
        end else if (bus_addr == GPT_ADDR_MASK) begin
            next_rdata[GPT_IRQ_W-1:0] = irq_mask;
        end
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bus_rdata <= GPT_RST_WORD;
        end else if (bus_rd) begin
            bus_rdata <= next_rdata;
        end else begin
            bus_rdata <= GPT_RST_WORD;
        end
    end

endmodule
`default_nettype wire

// file: verification/gpt_timer_asserts.sv
/*
 checker for the timer register port and interrupt line.
 assumes a bind to gpt_timer; sees only its ports.
*/
`default_nettype none
module gpt_timer_asserts
    import gpt_pkg::*;
#(
    parameter int NUM_SRC = GPT_NUM_SRC
) (
    input wire logic               ref_clk,
    input wire logic               nrst,
    input wire logic [31:0]        bus_addr,
    input wire logic [31:0]        bus_wdata,
    input wire logic               bus_wr,
    input wire logic               bus_rd,
    input wire logic [31:0]        bus_rdata,
    input wire logic               osc_32k_clk,
    input wire logic               undivided_pll_clock,
    input wire logic               external_clock_pin,
    input wire logic               low_power,
    input wire logic [NUM_SRC-1:0] irq_sources,
    input wire logic               irq
);
    logic [31:0] reload_q;
    logic [18:0] ctl_q;
    logic [7:0]  post_q;
    logic [1:0]  mask_q;
    logic        rd_bad;
    // clear register is write-only, so it reads like an unmapped place
    assign rd_bad = bus_rd && !(bus_addr inside {GPT_ADDR_RELOAD, GPT_ADDR_COUNT,
        GPT_ADDR_CONTROL, GPT_ADDR_CAPTURE, GPT_ADDR_STATUS, GPT_ADDR_MASK});
    // mirrors of writable fields only; count and capture move on their own
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reload_q <= '0;
            ctl_q <= '0;
            post_q <= '0;
            mask_q <= '0;
        end else if (bus_wr) begin
            if (bus_addr == GPT_ADDR_RELOAD) reload_q <= bus_wdata;
            if (bus_addr == GPT_ADDR_MASK) mask_q <= bus_wdata[1:0];
            if (bus_addr == GPT_ADDR_CONTROL) ctl_q <= bus_wdata[18:0];
            if (bus_addr == GPT_ADDR_CONTROL && bus_wdata[23]) post_q <= bus_wdata[31:24];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    chk_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == '0)
        else $error("read data outside answer cycle");
    chk_unmapped_zero: assert property ($past(rd_bad) |-> bus_rdata == '0)
        else $error("unmapped or write-only read not zero");
    chk_reload_back: assert property (bus_rd && bus_addr == GPT_ADDR_RELOAD |=>
        bus_rdata == $past(reload_q)) else $error("reload readback wrong");
    chk_ctl_back: assert property (bus_rd && bus_addr == GPT_ADDR_CONTROL |=>
        bus_rdata[18:0] == $past(ctl_q)) else $error("control readback wrong");
    chk_post_field: assert property (bus_rd && bus_addr == GPT_ADDR_CONTROL |=>
        bus_rdata[31:20] == {$past(post_q), 4'h0}) else $error("postscaler field wrong");
    chk_mask_back: assert property (bus_rd && bus_addr == GPT_ADDR_MASK |=>
        bus_rdata == {30'h0, $past(mask_q)}) else $error("mask readback wrong");
    chk_irq_masked: assert property (irq |-> $past(mask_q) != 2'h0)
        else $error("interrupt high with all sources masked");
    chk_status_width: assert property (bus_rd && bus_addr == GPT_ADDR_STATUS |=>
        bus_rdata[31:2] == '0) else $error("status upper bits set");
    cover property ($rose(irq));
    cover property (bus_wr && bus_addr == GPT_ADDR_CLEAR);
    cover property (bus_rd && bus_addr == GPT_ADDR_CAPTURE);
endmodule
`default_nettype wire

// file: verification/gpt_timer_bench.sv
/*
 self-checking bench for the timer registers, counting and interrupt.
 assumes package, timer and checker are compiled before it.
*/
`default_nettype none
module gpt_timer_bench;
    import gpt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [31:0] bus_addr = '0;
    logic [31:0] bus_wdata = '0;
    logic        bus_wr = 1'b0;
    logic        bus_rd = 1'b0;
    logic [31:0] bus_rdata;
    logic        osc_32k_clk = 1'b0;
    logic        undivided_pll_clock = 1'b0;
    logic        external_clock_pin = 1'b0;
    logic        low_power = 1'b0;
    logic [16:0] irq_sources = '0;
    logic        irq;
    logic [31:0] cyc = '0;
    logic [31:0] v, w;
    int          n_fail = 0;
    int          checks = 0;
    gpt_timer u_gpt_timer (.ref_clk(ref_clk), .nrst(nrst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .osc_32k_clk(osc_32k_clk), .undivided_pll_clock(undivided_pll_clock),
        .external_clock_pin(external_clock_pin), .low_power(low_power),
        .irq_sources(irq_sources), .irq(irq));
    always #20 ref_clk = ~ref_clk;
    // slow sources rise every 8, 4 and 16 cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 32'h1;
        osc_32k_clk <= cyc[2];
        undivided_pll_clock <= cyc[1];
        external_clock_pin <= cyc[3];
        if (cyc == 32'd60000) begin
            n_fail++;
            final_report();
        end
    end
    task automatic final_report();
        if (n_fail == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;
    endtask
    task automatic pair(input int g, output logic [31:0] a, output logic [31:0] b);
        rd(GPT_ADDR_COUNT, a);
        repeat (g - 2) @(posedge ref_clk);
        rd(GPT_ADDR_COUNT, b);
    endtask
    task automatic pulse(input int i);
        @(posedge ref_clk);
        irq_sources[i] <= 1'b1;
        repeat (2) @(posedge ref_clk);
        irq_sources[i] <= 1'b0;
    endtask
    task automatic t_regs();
        logic [31:0] map[8] = '{GPT_ADDR_RELOAD, GPT_ADDR_COUNT, GPT_ADDR_CONTROL,
            GPT_ADDR_CLEAR, GPT_ADDR_CAPTURE, GPT_ADDR_STATUS, GPT_ADDR_MASK, 32'hffff033c};
        foreach (map[i]) begin
            rd(map[i], v);
            cmp32(v, GPT_RST_WORD);
        end
        wr(GPT_ADDR_COUNT, 32'h55);
        rd(GPT_ADDR_COUNT, v);
        cmp32(v, 32'h0);
        wr(GPT_ADDR_CONTROL, 32'h5a00_0000);
        rd(GPT_ADDR_CONTROL, v);
        cmp32(v, 32'h0);
        wr(GPT_ADDR_CONTROL, 32'h5a80_0000);
        rd(GPT_ADDR_CONTROL, v);
        cmp32(v, 32'h5a00_0000);
    endtask
    task automatic t_count();
        logic [31:0] ctl[7] = '{32'h380, 32'h384, 32'h388, 32'h38f, 32'h381, 32'h280, 32'h300};
        int          gap[7] = '{2, 16, 256, 32768, 2, 2, 16};
        logic [31:0] dif[7] = '{2, 1, 1, 1, 2, 32'hffff_fffe, 0};
        wr(GPT_ADDR_RELOAD, 32'h1000);
        foreach (ctl[i]) begin
            wr(GPT_ADDR_CONTROL, ctl[i]);
            wr(GPT_ADDR_CLEAR, 32'h0);
            pair(gap[i], v, w);
            cmp32(w - v, dif[i]);
        end
    endtask
    task automatic t_src();
        int per[4] = '{8, 1, 4, 16};
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 2; p++) begin
                @(posedge ref_clk);
                low_power <= p[0];
                wr(GPT_ADDR_CONTROL, 32'h180 | (s << 9));
                wr(GPT_ADDR_CLEAR, 32'h0);
                pair(16, v, w);
                cmp32(w - v, (p == 1 && (s == 1 || s == 2)) ? 0 : 16 / per[s]);
            end
        end
        @(posedge ref_clk);
        low_power <= 1'b0;
    endtask
    task automatic t_irq();
        wr(GPT_ADDR_RELOAD, 32'h5);
        wr(GPT_ADDR_CONTROL, 32'h2c0);
        wr(GPT_ADDR_CLEAR, 32'h0);
        repeat (20) @(posedge ref_clk);
        #1 cmp1(irq, 1'b0);
        rd(GPT_ADDR_STATUS, v);
        cmp32(v, 32'h1);
        rd(GPT_ADDR_COUNT, v);
        cmp1(v <= 32'h5, 1'b1);
        wr(GPT_ADDR_MASK, 32'h1);
        repeat (2) @(posedge ref_clk);
        #1 cmp1(irq, 1'b1);
        wr(GPT_ADDR_CONTROL, 32'h0);
        wr(GPT_ADDR_CLEAR, 32'h0);
        repeat (3) @(posedge ref_clk);
        #1 cmp1(irq, 1'b0);
        wr(GPT_ADDR_CONTROL, 32'h0184_02c0);
        repeat (8) @(posedge ref_clk);
        #1 cmp1(irq, 1'b0);
        repeat (6) @(posedge ref_clk);
        #1 cmp1(irq, 1'b1);
        wr(GPT_ADDR_CONTROL, 32'h0);
        wr(GPT_ADDR_STATUS, 32'h1);
        repeat (3) @(posedge ref_clk);
        #1 cmp1(irq, 1'b0);
        wr(GPT_ADDR_RELOAD, 32'h0);
        wr(GPT_ADDR_CLEAR, 32'h0);
        wr(GPT_ADDR_CONTROL, 32'h280);
        rd(GPT_ADDR_COUNT, v);
        cmp1(v > 32'hffff_ff00, 1'b1);
        wr(GPT_ADDR_CONTROL, 32'h0);
        wr(GPT_ADDR_MASK, 32'h0);
    endtask
    task automatic t_cap();
        for (int k = 0; k < 2; k++) begin
            wr(GPT_ADDR_RELOAD, 32'ha00 + 16 * k);
            wr(GPT_ADDR_CLEAR, 32'h0);
            wr(GPT_ADDR_CONTROL, 32'h20000 | (16 * k << 12));
            pulse(16 - 16 * k);
            rd(GPT_ADDR_CAPTURE, v);
            cmp32(v, k * 32'ha00);
            pulse(16 * k);
            rd(GPT_ADDR_CAPTURE, v);
            cmp32(v, 32'ha00 + 16 * k);
            rd(GPT_ADDR_STATUS, v);
            cmp1(v[1], 1'b1);
        end
        wr(GPT_ADDR_CONTROL, 32'h10000);
        wr(GPT_ADDR_RELOAD, 32'h77);
        wr(GPT_ADDR_CLEAR, 32'h0);
        pulse(16);
        wr(GPT_ADDR_CAPTURE, 32'h0);
        rd(GPT_ADDR_CAPTURE, v);
        cmp32(v, 32'ha10);
        wr(GPT_ADDR_STATUS, 32'h3);
    endtask
    task automatic t_hms();
        logic [31:0] ctl[4] = '{32'h3a8, 32'h2a8, 32'h2b8, 32'h2a8};
        logic [31:0] ld[4] = '{32'h013b3b63, 32'h0, 32'h0, 32'h01000000};
        logic [31:0] ex[4] = '{32'h02000000, 32'h173b3b63, 32'hff3b3b63, 32'h003b3b63};
        foreach (ctl[i]) begin
            wr(GPT_ADDR_RELOAD, ld[i]);
            wr(GPT_ADDR_CONTROL, ctl[i]);
            wr(GPT_ADDR_CLEAR, 32'h0);
            pair(300, v, w);
            cmp32(v, ld[i]);
            cmp32(w, ex[i]);
        end
        wr(GPT_ADDR_CONTROL, 32'h0);
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        t_regs();
        t_count();
        t_src();
        t_irq();
        t_cap();
        t_hms();
        final_report();
    end
endmodule
bind gpt_timer gpt_timer_asserts #(.NUM_SRC(NUM_SRC)) u_gpt_timer_asserts (
    .ref_clk(ref_clk), .nrst(nrst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .osc_32k_clk(osc_32k_clk),
    .undivided_pll_clock(undivided_pll_clock), .external_clock_pin(external_clock_pin),
    .low_power(low_power), .irq_sources(irq_sources), .irq(irq));
`default_nettype wire
